// ---- rtl/fpcd_pkg.sv ----
// package: command codes, unlock addresses and bus timing for the protection command host
package fpcd_pkg;
	localparam int ADDR_W = 12;                        // address bits driven onto the flash bus
	localparam int DATA_W = 8;                         // command/data byte width
	// unlock addresses, word and byte mode
	localparam logic [11:0] UNLOCK1_WORD = 12'h555;
	localparam logic [11:0] UNLOCK2_WORD = 12'h2AA;
	localparam logic [11:0] UNLOCK1_BYTE = 12'hAAA;
	localparam logic [11:0] UNLOCK2_BYTE = 12'h555;
	localparam logic [11:0] ANY_ADDR = 12'h000;        // address used where any address is legal
	localparam logic [11:0] ERASE_ALL_ADDR = 12'h000;  // fixed address of the erase-all confirm
	// data codes
	localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [7:0] CODE_SLEEP = 8'hB9;
	localparam logic [7:0] CODE_WAKE = 8'hAB;
	localparam logic [7:0] CODE_LOCKREG_ENTRY = 8'h40;
	localparam logic [7:0] CODE_NVPROT_ENTRY = 8'hC0;
	localparam logic [7:0] CODE_PROGRAM = 8'hA0;
	localparam logic [7:0] CODE_EXIT1 = 8'h90;
	localparam logic [7:0] CODE_EXIT2 = 8'h00;
	localparam logic [7:0] CODE_SECT_PROG = 8'h00;
	localparam logic [7:0] CODE_ERASE1 = 8'h80;
	localparam logic [7:0] CODE_ERASE2 = 8'h30;
	localparam logic [7:0] STATUS_LOCKED = 8'h00;      // status read: sector protected
	localparam logic [7:0] STATUS_UNLOCKED = 8'h01;    // status read: sector unprotected
	// bus timing at 20 MHz
	localparam int CLK_NS = 50;
	localparam int STROBE_NS = 100;                    // least write/read strobe width
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// host commands
	typedef enum logic [2:0] {
		FPCD_CMD_SLEEP = 3'b000,
		FPCD_CMD_WAKE = 3'b001,
		FPCD_CMD_LOCKREG_PROG = 3'b010,
		FPCD_CMD_LOCKREG_READ = 3'b011,
		FPCD_CMD_SECT_PROG = 3'b100,
		FPCD_CMD_ERASE_ALL = 3'b101,
		FPCD_CMD_SECT_STATUS = 3'b110
	} fpcd_cmd_t;
endpackage : fpcd_pkg

// ---- rtl/fpcd_bus_cycle.sv ----
// one flash bus cycle: drives address, data and strobes for a fixed strobe width
`timescale 1ns/1ps
module fpcd_bus_cycle
	import fpcd_pkg::*;
#(
	parameter int STROBE = STROBE_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic isRead,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] busDataIn,
	output logic [11:0] busAddr_r,
	output logic [7:0] busDataOut_r,
	output logic busDataOe_n_r,
	output logic busWe_n_r,
	output logic busOe_n_r,
	output logic busCe_n_r,
	output logic done_r,
	output logic [7:0] rdata_r
);
	logic [7:0] cnt_r; // strobe cycles left
	logic active_r;    // a cycle is on the bus

	// strobe timing and pins
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 8'h00;
			active_r <= 1'b0;
			busAddr_r <= 12'h000;
			busDataOut_r <= 8'h00;
			busDataOe_n_r <= 1'b1;
			busWe_n_r <= 1'b1;
			busOe_n_r <= 1'b1;
			busCe_n_r <= 1'b1;
			done_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			done_r <= 1'b0;
			if (start && !active_r)
			begin
				// address and data settle with the strobe; the flash model takes the write just after the write strobe falls
				active_r <= 1'b1;
				cnt_r <= 8'(STROBE);
				busAddr_r <= addr;
				busDataOut_r <= wdata;
				busDataOe_n_r <= isRead;
				busCe_n_r <= 1'b0;
				busWe_n_r <= isRead;
				busOe_n_r <= !isRead;
			end
			else if (active_r)
			begin
				if (cnt_r > 8'h01)
					cnt_r <= cnt_r - 8'h01;
				else
				begin
					// end of strobe: sample read data before releasing output enable
					if (!busOe_n_r)
						rdata_r <= busDataIn;
					active_r <= 1'b0;
					busWe_n_r <= 1'b1;
					busOe_n_r <= 1'b1;
					busCe_n_r <= 1'b1;
					busDataOe_n_r <= 1'b1;
					done_r <= 1'b1;
				end
			end
		end
	end
endmodule : fpcd_bus_cycle

// ---- rtl/fpcd_host.sv ----
// host controller issuing protection and power-down command sequences to the flash
//
// Function
// - sleep: AA@555, 55@2AA, B9 anywhere
// - wake: single AB write, no unlock
// - byte mode: unlock addresses AAA and 555
// - lock register: A0 then data; read
// - leave lock register set: 90 then 00
// - sector protect: C0 entry, A0, 00@sector
// - only defined command codes are issued
`timescale 1ns/1ps
module fpcd_host
	import fpcd_pkg::*;
#(
	parameter int STROBE = STROBE_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire fpcd_cmd_t cmdCode,
	input wire logic byteMode,
	input wire logic [11:0] cmdSectorAddr,
	input wire logic [7:0] cmdData,
	input wire logic [7:0] flashDataIn,
	output logic cmdReady_r,
	output logic cmdDone_r,
	output logic [7:0] rspData_r,
	output logic sectorLocked_r,
	output logic [11:0] flashAddr_r,
	output logic [7:0] flashDataOut_r,
	output logic flashDataOe_n_r,
	output logic flashWe_n_r,
	output logic flashOe_n_r,
	output logic flashCe_n_r
);
	typedef enum logic [1:0] {
		FPCD_IDLE = 2'b00,
		FPCD_ISSUE = 2'b01,
		FPCD_WAIT = 2'b10,
		FPCD_FIN = 2'b11
	} fpcd_state_t;

	fpcd_state_t state_r;        // sequencer state
	fpcd_cmd_t cmd_r;            // command being run
	logic byte_r;                // mode latched for the whole sequence
	logic [11:0] sect_r;         // latched sector address
	logic [7:0] data_r;          // latched lock register data
	logic [3:0] step_r;          // bus cycle index in the sequence
	logic [3:0] nsteps;          // cycles in the current sequence
	logic stepRead;              // current step is a read
	logic [11:0] stepAddr;       // current step address
	logic [7:0] stepData;        // current step data
	logic cycStart;              // starts one bus cycle
	logic cycDone;               // bus cycle finished
	logic [7:0] cycRdata;        // data captured by the bus cycle

	// unlock addresses in word or byte mode
	function automatic logic [11:0] unlockAddr(input logic second, input logic isByte);
		if (second)
			unlockAddr = isByte ? UNLOCK2_BYTE : UNLOCK2_WORD;
		else
			unlockAddr = isByte ? UNLOCK1_BYTE : UNLOCK1_WORD;
	endfunction : unlockAddr

	// sequence table; apart from the lock register data byte (data_r), only codes of the defined set appear here
	always_comb
	begin
		nsteps = 4'd1;
		stepRead = 1'b0;
		stepAddr = ANY_ADDR;
		stepData = CODE_EXIT2;
		case (cmd_r)
			FPCD_CMD_SLEEP:
			begin
				nsteps = 4'd3;
				if (step_r == 4'd0)
				begin
					stepAddr = unlockAddr(1'b0, byte_r);
					stepData = CODE_UNLOCK1;
				end
				else if (step_r == 4'd1)
				begin
					stepAddr = unlockAddr(1'b1, byte_r);
					stepData = CODE_UNLOCK2;
				end
				else
					stepData = CODE_SLEEP;
			end
			FPCD_CMD_WAKE:
			begin
				nsteps = 4'd1;
				stepData = CODE_WAKE;
			end
			FPCD_CMD_LOCKREG_PROG, FPCD_CMD_LOCKREG_READ:
			begin
				// entry, then program or read, then exit
				// program carries A0, data and a readback; read carries only the read
				nsteps = (cmd_r == FPCD_CMD_LOCKREG_PROG) ? 4'd8 : 4'd6;
				case (step_r)
					4'd0:
					begin
						stepAddr = unlockAddr(1'b0, byte_r);
						stepData = CODE_UNLOCK1;
					end
					4'd1:
					begin
						stepAddr = unlockAddr(1'b1, byte_r);
						stepData = CODE_UNLOCK2;
					end
					4'd2:
					begin
						stepAddr = unlockAddr(1'b0, byte_r);
						stepData = CODE_LOCKREG_ENTRY;
					end
					default:
					begin
						if (cmd_r == FPCD_CMD_LOCKREG_PROG && step_r == 4'd3)
							stepData = CODE_PROGRAM;
						else if (cmd_r == FPCD_CMD_LOCKREG_PROG && step_r == 4'd4)
							stepData = data_r;
						else if (step_r == nsteps - 4'd3)
							stepRead = 1'b1;
						else if (step_r == nsteps - 4'd2)
							stepData = CODE_EXIT1;
						else
							stepData = CODE_EXIT2;
					end
				endcase
			end
			default:
			begin
				// protection set: entry, program or erase-all operation (none for status), status read, exit
				nsteps = (cmd_r == FPCD_CMD_SECT_STATUS) ? 4'd6 : 4'd8;
				case (step_r)
					4'd0:
					begin
						stepAddr = unlockAddr(1'b0, byte_r);
						stepData = CODE_UNLOCK1;
					end
					4'd1:
					begin
						stepAddr = unlockAddr(1'b1, byte_r);
						stepData = CODE_UNLOCK2;
					end
					4'd2:
					begin
						stepAddr = unlockAddr(1'b0, byte_r);
						stepData = CODE_NVPROT_ENTRY;
					end
					default:
					begin
						if (cmd_r == FPCD_CMD_SECT_PROG && step_r == 4'd3)
							stepData = CODE_PROGRAM;
						else if (cmd_r == FPCD_CMD_SECT_PROG && step_r == 4'd4)
						begin
							stepAddr = sect_r;
							stepData = CODE_SECT_PROG;
						end
						else if (cmd_r == FPCD_CMD_ERASE_ALL && step_r == 4'd3)
							stepData = CODE_ERASE1;
						else if (cmd_r == FPCD_CMD_ERASE_ALL && step_r == 4'd4)
						begin
							stepAddr = ERASE_ALL_ADDR;
							stepData = CODE_ERASE2;
						end
						else if (step_r == nsteps - 4'd3)
						begin
							stepAddr = sect_r;
							stepRead = 1'b1;
						end
						else if (step_r == nsteps - 4'd2)
							stepData = CODE_EXIT1;
						else
							stepData = CODE_EXIT2;
					end
				endcase
			end
		endcase
	end

	assign cycStart = (state_r == FPCD_ISSUE);

	// one bus cycle engine, reused by every step
	fpcd_bus_cycle #(
		.STROBE(STROBE)
	) uCycle (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(cycStart),
		.isRead(stepRead),
		.addr(stepAddr),
		.wdata(stepData),
		.busDataIn(flashDataIn),
		.busAddr_r(flashAddr_r),
		.busDataOut_r(flashDataOut_r),
		.busDataOe_n_r(flashDataOe_n_r),
		.busWe_n_r(flashWe_n_r),
		.busOe_n_r(flashOe_n_r),
		.busCe_n_r(flashCe_n_r),
		.done_r(cycDone),
		.rdata_r(cycRdata)
	);

	// sequencer; every sequence is sent whole, and every command set sequence ends with exit so a
	// dropped partial sequence on the device leaves it in read mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= FPCD_IDLE;
			cmd_r <= FPCD_CMD_WAKE;
			byte_r <= 1'b0;
			sect_r <= 12'h000;
			data_r <= 8'h00;
			step_r <= 4'd0;
			cmdReady_r <= 1'b0;
			cmdDone_r <= 1'b0;
		end
		else
		begin
			cmdDone_r <= 1'b0;
			case (state_r)
				FPCD_IDLE:
				begin
					cmdReady_r <= 1'b1;
					if (cmdValid && cmdReady_r)
					begin
						cmd_r <= cmdCode;
						byte_r <= byteMode;
						sect_r <= cmdSectorAddr;
						data_r <= cmdData;
						step_r <= 4'd0;
						cmdReady_r <= 1'b0;
						state_r <= FPCD_ISSUE;
					end
				end
				FPCD_ISSUE:
					state_r <= FPCD_WAIT;
				FPCD_WAIT:
				begin
					if (cycDone)
					begin
						if (step_r == nsteps - 4'd1)
							state_r <= FPCD_FIN;
						else
						begin
							step_r <= step_r + 4'd1;
							state_r <= FPCD_ISSUE;
						end
					end
				end
				default:
				begin
					cmdDone_r <= 1'b1;
					state_r <= FPCD_IDLE;
				end
			endcase
		end
	end

	// read results: lock register byte or sector status
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rspData_r <= 8'h00;
			sectorLocked_r <= 1'b0;
		end
		else if (state_r == FPCD_WAIT && cycDone && stepRead)
		begin
			rspData_r <= cycRdata;
			if (cmd_r == FPCD_CMD_SECT_STATUS)
				sectorLocked_r <= (cycRdata == STATUS_LOCKED);
		end
	end
endmodule : fpcd_host

// ---- tb/fpcd_flash_model.sv ----
// behavioural flash device answering the protection and power-down commands
`timescale 1ns/1ps
module fpcd_flash_model
	import fpcd_pkg::*;
(
	input wire logic byteMode,
	input wire logic [11:0] addr,
	input wire logic [7:0] dataIn,
	input wire logic dataOe_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic ce_n,
	output logic [7:0] dataOut,
	output logic sleeping,
	output logic [1:0] mode,
	output logic [7:0] lockReg,
	output int wrCnt,
	output int rdCnt,
	output logic oddCode
);
	logic [1:0] step; // unlock progress
	logic [7:0] pend; // first write of a two-write command
	logic [15:0] prot; // persistent_sector_lock_bit per sector, 1 = locked
	logic [7:0] rdVal; // value presented on a read
	logic [7:0] heldV; // last read value, inverted once released
	logic [11:0] a;
	logic [7:0] d;
	logic [11:0] u1;
	logic [11:0] u2;
	assign u1 = byteMode ? UNLOCK1_BYTE : UNLOCK1_WORD;
	assign u2 = byteMode ? UNLOCK2_BYTE : UNLOCK2_WORD;
	initial
	begin
		{step, pend, prot, sleeping, mode, lockReg, heldV, oddCode} = '0;
		wrCnt = 0;
		rdCnt = 0;
	end
	// a write is taken after the strobe falls; host holds address and data stable meanwhile
	always @(negedge we_n)
	begin
		#1;
		a = addr;
		d = dataOe_n ? ~dataIn : dataIn;
		wrCnt++;
		if (ce_n)
			d = 8'h00; // unselected: ignored below
		else if (sleeping)
		begin
			if (d == CODE_WAKE)
				sleeping = 1'h0;
		end
		else if (mode != 2'h0)
		begin
			if (pend == CODE_PROGRAM)
			begin
				if (mode == 2'h1)
					lockReg = d;
				else if (d == CODE_SECT_PROG)
					prot[a[3:0]] = 1'h1;
				pend = 8'h00;
			end
			else if (pend == CODE_ERASE1)
			begin
				if (d == CODE_ERASE2 && a == ERASE_ALL_ADDR)
					prot = '0;
				pend = 8'h00;
			end
			else if (pend == CODE_EXIT1)
			begin
				if (d == CODE_EXIT2)
					mode = 2'h0;
				pend = 8'h00;
			end
			else
			begin
				// anything but a known first write of a two-write command is undefined
				if (d != CODE_PROGRAM && d != CODE_ERASE1 && d != CODE_EXIT1)
					oddCode = 1'h1;
				pend = d;
			end
		end
		// a mismatch anywhere drops the partial unlock
		else if (step == 2'h0)
			step = (d == CODE_UNLOCK1 && a == u1) ? 2'h1 : 2'h0;
		else if (step == 2'h1)
			step = (d == CODE_UNLOCK2 && a == u2) ? 2'h2 : 2'h0;
		else
		begin
			step = 2'h0;
			if (d == CODE_SLEEP)
				sleeping = 1'h1;
			else if (a == u1 && d == CODE_LOCKREG_ENTRY)
				mode = 2'h1;
			else if (a == u1 && d == CODE_NVPROT_ENTRY)
				mode = 2'h2;
			else
				oddCode = 1'h1;
		end
	end
	// read data follows the current command set
	always_comb
		rdVal = (mode == 2'h1) ? lockReg : (mode == 2'h2) ? (prot[addr[3:0]] ? STATUS_LOCKED : STATUS_UNLOCKED) : 8'hFF;
	// select and output enable fall together; wait so the select is settled
	always @(negedge oe_n)
	begin
		#1;
		if (!ce_n)
			rdCnt++;
	end
	always @(posedge oe_n)
		heldV = rdVal;
	// released bus shows no stale value, so a late sample cannot pass by luck
	assign dataOut = (!oe_n && !ce_n) ? rdVal : ~heldV;
endmodule : fpcd_flash_model

// ---- tb/fpcd_host_asserts.sv ----
// checker for the flash protection command host ports
`timescale 1ns/1ps
module fpcd_host_asserts
	import fpcd_pkg::*;
#(
	parameter int STROBE = STROBE_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire fpcd_cmd_t cmdCode,
	input wire logic byteMode,
	input wire logic cmdReady_r,
	input wire logic cmdDone_r,
	input wire logic [11:0] flashAddr_r,
	input wire logic [7:0] flashDataOut_r,
	input wire logic flashDataOe_n_r,
	input wire logic flashWe_n_r,
	input wire logic flashOe_n_r,
	input wire logic flashCe_n_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	int lowCnt; // consecutive cycles with the write strobe low
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			lowCnt <= 0;
		else
			lowCnt <= flashWe_n_r ? 0 : lowCnt + 1;
	sequence takeS;
		cmdValid && cmdReady_r;
	endsequence
	sequence wrS(logic [11:0] a, logic [7:0] d);
		$fell(flashWe_n_r) && flashAddr_r == a && flashDataOut_r == d;
	endsequence
	take_busy_a: assert property (takeS |=> !cmdReady_r) else $error("ready stayed high after a take");
	done_ready_a: assert property (cmdDone_r |-> !cmdReady_r ##1 cmdReady_r) else $error("ready not back after done");
	done_bound_a: assert property (takeS |-> ##[1:60] cmdDone_r) else $error("command never finished");
	write_drive_a: assert property (!flashWe_n_r |-> flashOe_n_r && !flashCe_n_r && !flashDataOe_n_r)
		else $error("write without select or data drive");
	read_release_a: assert property (!flashOe_n_r |-> flashDataOe_n_r && !flashCe_n_r) else $error("read while driving");
	strobe_width_a: assert property ($rose(flashWe_n_r) |-> lowCnt >= STROBE) else $error("write strobe too short");
	unlock_first_a: assert property (takeS ##0 cmdCode != FPCD_CMD_WAKE |-> ##[1:6]
		wrS(byteMode ? UNLOCK1_BYTE : UNLOCK1_WORD, CODE_UNLOCK1)) else $error("first unlock write wrong");
	unlock_second_a: assert property (takeS ##0 cmdCode != FPCD_CMD_WAKE |-> ##[1:12]
		wrS(byteMode ? UNLOCK2_BYTE : UNLOCK2_WORD, CODE_UNLOCK2)) else $error("second unlock write wrong");
	wake_single_a: assert property (takeS ##0 cmdCode == FPCD_CMD_WAKE |-> ##[1:6] wrS(ANY_ADDR, CODE_WAKE))
		else $error("wake write wrong");
endmodule : fpcd_host_asserts
bind fpcd_host fpcd_host_asserts #(.STROBE(STROBE)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
	.cmdCode(cmdCode), .byteMode(byteMode), .cmdReady_r(cmdReady_r), .cmdDone_r(cmdDone_r), .flashAddr_r(flashAddr_r),
	.flashDataOut_r(flashDataOut_r), .flashDataOe_n_r(flashDataOe_n_r), .flashWe_n_r(flashWe_n_r),
	.flashOe_n_r(flashOe_n_r), .flashCe_n_r(flashCe_n_r));

// ---- tb/testbench.sv ----
// self-checking bench for the protection command host with a flash model
`timescale 1ns/1ps
module testbench
	import fpcd_pkg::*;
;
	logic clk_sys, rst_n, cmdValid, byteMode, cmdReady_r, cmdDone_r, sectorLocked_r, dOe_n, we_n, oe_n, ce_n;
	fpcd_cmd_t cmdCode;
	logic [11:0] cmdSectorAddr, fAddr;
	logic [7:0] cmdData, fIn, fOut, rspData_r, lockReg;
	logic sleeping;
	logic oddCode;
	logic [1:0] mode;
	int wrCnt, rdCnt, err_count, check_count;
	fpcd_host #(.STROBE(2)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.byteMode(byteMode), .cmdSectorAddr(cmdSectorAddr), .cmdData(cmdData), .flashDataIn(fIn),
		.cmdReady_r(cmdReady_r), .cmdDone_r(cmdDone_r), .rspData_r(rspData_r), .sectorLocked_r(sectorLocked_r),
		.flashAddr_r(fAddr), .flashDataOut_r(fOut), .flashDataOe_n_r(dOe_n), .flashWe_n_r(we_n),
		.flashOe_n_r(oe_n), .flashCe_n_r(ce_n));
	fpcd_flash_model u_flash (.byteMode(byteMode), .addr(fAddr), .dataIn(fOut), .dataOe_n(dOe_n), .we_n(we_n),
		.oe_n(oe_n), .ce_n(ce_n), .dataOut(fIn), .sleeping(sleeping), .mode(mode), .lockReg(lockReg),
		.wrCnt(wrCnt), .rdCnt(rdCnt), .oddCode(oddCode));
	initial
	begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	task print_verdict;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'h1)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	// one command; inputs change at the falling edge, bus cycles counted on the device side
	task doCmd(input fpcd_cmd_t c, input logic [11:0] s, input logic [7:0] d, input int nw, input int nr);
		int w0, r0, n;
		w0 = wrCnt;
		r0 = rdCnt;
		for (n = 0; cmdReady_r !== 1'h1 && n < 200; n++) @(negedge clk_sys);
		if (n >= 200)
		begin
			err_count++;
			print_verdict();
		end
		{cmdCode, cmdSectorAddr, cmdData, cmdValid} = {c, s, d, 1'h1};
		@(negedge clk_sys);
		cmdValid = 1'h0;
		for (n = 0; cmdDone_r !== 1'h1 && n < 200; n++) @(negedge clk_sys);
		if (n >= 200)
		begin
			err_count++;
			print_verdict();
		end
		@(negedge clk_sys);
		chk(wrCnt - w0 == nw && rdCnt - r0 == nr, "bus cycle count");
	endtask : doCmd
	task sleep_wake(input logic bm);
		byteMode = bm;
		doCmd(FPCD_CMD_SLEEP, 12'h000, 8'h00, 3, 0);
		chk(sleeping === 1'h1, "not asleep");
		doCmd(FPCD_CMD_WAKE, 12'h000, 8'h00, 1, 0);
		chk(sleeping === 1'h0, "still asleep");
	endtask : sleep_wake
	task lock_reg;
		doCmd(FPCD_CMD_LOCKREG_PROG, 12'h000, 8'h5A, 7, 1);
		chk(lockReg === 8'h5A && rspData_r === 8'h5A && mode === 2'h0, "lock program");
		doCmd(FPCD_CMD_LOCKREG_READ, 12'h000, 8'h00, 5, 1);
		chk(rspData_r === 8'h5A, "lock read");
	endtask : lock_reg
	task sector_prot;
		doCmd(FPCD_CMD_SECT_PROG, 12'h003, 8'h00, 7, 1);
		doCmd(FPCD_CMD_SECT_STATUS, 12'h003, 8'h00, 5, 1);
		chk(sectorLocked_r === 1'h1 && rspData_r === STATUS_LOCKED, "sector not locked");
		doCmd(FPCD_CMD_SECT_STATUS, 12'h004, 8'h00, 5, 1);
		chk(sectorLocked_r === 1'h0 && rspData_r === STATUS_UNLOCKED, "neighbour locked");
		doCmd(FPCD_CMD_ERASE_ALL, 12'h003, 8'h00, 7, 1);
		doCmd(FPCD_CMD_SECT_STATUS, 12'h003, 8'h00, 5, 1);
		chk(sectorLocked_r === 1'h0 && mode === 2'h0, "erase all failed");
	endtask : sector_prot
	initial
	begin
		{rst_n, cmdValid, byteMode, cmdCode, cmdSectorAddr, cmdData} = '0;
		err_count = 0;
		check_count = 0;
		repeat (12) @(negedge clk_sys);
		chk(we_n === 1'h1 && oe_n === 1'h1 && ce_n === 1'h1 && cmdReady_r === 1'h0, "reset outputs");
		rst_n = 1'h1;
		sleep_wake(1'h0);
		sleep_wake(1'h1);
		lock_reg();
		byteMode = 1'h0;
		sector_prot();
		chk(oddCode === 1'h0, "undefined command code seen");
		print_verdict();
	end
endmodule : testbench
